/* latch_loader_pkg.sv */
package latch_loader_pkg;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Word layout
  // ****************************************
  localparam int WORD_BITS  = 32;
  localparam int BYTE_BITS  = 8;
  localparam int ADDR_BITS  = 3;
  localparam int NUM_LATCH  = 6;
  localparam logic [2:0] TOP_LATCH = 3'h5;
  localparam logic [31:0] LATCH_RESET = 32'h0000_0000;
  // Idle pin levels and chip enable reset level; synchronisers reset to these so no false edge follows reset
  localparam logic SCLK_IDLE    = 1'b0;
  localparam logic SDATA_IDLE   = 1'b0;
  localparam logic STROBE_IDLE  = 1'b1;
  localparam logic CE_RESET_LVL = 1'b0;
  // ****************************************
  // Timing
  // ****************************************
  localparam int SYS_CLK_HZ   = 10_000_000;
  localparam int LINK_DIV     = 4;
  localparam int SYNC_STAGES  = 3;
endpackage

/* latch_loader_if.sv */
interface latch_loader_if;
  timeunit 1ns;
  timeprecision 1ps;
  logic serial_clk;
  logic serial_data;
  logic load_strobe;
  logic chip_enable;
  logic selectable_status_pin;
  modport device (
    input  serial_clk,
    input  serial_data,
    input  load_strobe,
    input  chip_enable,
    output selectable_status_pin
  );
  modport host (
    output serial_clk,
    output serial_data,
    output load_strobe,
    output chip_enable,
    input  selectable_status_pin
  );
endinterface

/* latch_loader_device.sv */
// Summary of operation
// [R1] Shift data in on each clock rise
// [R2] Strobe rise copies word to addressed latch
// [R3] Host lowers strobe before each word
// [R4] Host sends word as four bytes
// [R5] Host raises strobe after last byte
// [R6] Host writes six latches, highest first
// [R7] Host data changes before clock rise
// [R8] Chip enable input powers device down
// [R9] Status pin reports lock when selected
// [R10] MSB first; address bits shifted last
module latch_loader_device #(
  // Word and latch geometry
  parameter int WORD_W  = latch_loader_pkg::WORD_BITS,
  parameter int ADDR_W  = latch_loader_pkg::ADDR_BITS,
  parameter int LATCHES = latch_loader_pkg::NUM_LATCH
) (
  // Clock and reset
  input  wire logic          sys_clk_in,
  input  wire logic          rst_in,
  // Serial link
  latch_loader_if.device     link,
  // User side
  input  wire logic          lock_in,
  input  wire logic          status_is_lock_in,
  output logic [WORD_W-1:0]  latch_out [0:LATCHES-1],
  output logic [LATCHES-1:0] latch_written_out,
  output logic               powered_down_out,
  output logic               outputs_active_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Local constants and helpers
  // ****************************************
  localparam int SYNC_W = latch_loader_pkg::SYNC_STAGES;
  localparam int LAST   = SYNC_W - 1;
  localparam int MID    = SYNC_W - 2;

  typedef logic [SYNC_W-1:0] sync_t;

  // The clock, data and strobe synchronisers reset to the idle level of their pin, so that no false
  // edge is seen when reset is released; chip enable resets to its off level
  localparam sync_t             CLK_SYNC_IDLE = {SYNC_W{latch_loader_pkg::SCLK_IDLE}};
  localparam sync_t             DAT_SYNC_IDLE = {SYNC_W{latch_loader_pkg::SDATA_IDLE}};
  localparam sync_t             LE_SYNC_IDLE  = {SYNC_W{latch_loader_pkg::STROBE_IDLE}};
  localparam sync_t             CE_SYNC_IDLE  = {SYNC_W{latch_loader_pkg::CE_RESET_LVL}};
  localparam logic [WORD_W-1:0] WORD_RESET    = WORD_W'(latch_loader_pkg::LATCH_RESET);
  localparam logic [ADDR_W-1:0] ADDR_TOP      = ADDR_W'(latch_loader_pkg::TOP_LATCH);

  // A pin level only counts once the second and third stages agree
  function automatic logic stages_agree(input sync_t stages);
    return stages[MID] == stages[LAST];
  endfunction

  // Level seen by the core: follows the last stage only while it is settled
  function automatic logic settled_level(input sync_t stages, input logic level);
    return stages_agree(stages) ? stages[LAST] : level;
  endfunction

  // One-hot latch select; addresses past the last latch select nothing
  function automatic logic [LATCHES-1:0] latch_onehot(input logic [ADDR_W-1:0] addr);
    logic [LATCHES-1:0] hot;
    hot = '0;
    for (int k = 0; k < LATCHES; k++) begin
      if (addr == ADDR_W'(k)) begin
        hot[k] = 1'b1;
      end
    end
    return hot;
  endfunction

  // ****************************************
  // Three-stage pin synchronisers
  // ****************************************
  sync_t clk_sync_reg;
  sync_t dat_sync_reg;
  sync_t le_sync_reg;
  sync_t ce_sync_reg;

  // Serial clock is only sampled; its edges are found below
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      clk_sync_reg <= CLK_SYNC_IDLE;
    end else begin
      clk_sync_reg <= {clk_sync_reg[MID:0], link.serial_clk};
    end
  end

  // Same depth as the clock, so the lead of data before each rise is kept
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      dat_sync_reg <= DAT_SYNC_IDLE;
    end else begin
      dat_sync_reg <= {dat_sync_reg[MID:0], link.serial_data};
    end
  end

  // Strobe idles high; a reset level of zero would fake a commit
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      le_sync_reg <= LE_SYNC_IDLE;
    end else begin
      le_sync_reg <= {le_sync_reg[MID:0], link.load_strobe};
    end
  end

  // Chip enable counts as off until its pin level has settled
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ce_sync_reg <= CE_SYNC_IDLE;
    end else begin
      ce_sync_reg <= {ce_sync_reg[MID:0], link.chip_enable};
    end
  end

  // ****************************************
  // Settled levels and edges
  // ****************************************
  logic clk_lvl_reg;
  logic dat_lvl_reg;
  logic le_lvl_reg;
  logic ce_lvl_reg;

  wire clk_lvl_next = settled_level(clk_sync_reg, clk_lvl_reg);
  wire dat_lvl_next = settled_level(dat_sync_reg, dat_lvl_reg);
  wire le_lvl_next  = settled_level(le_sync_reg, le_lvl_reg);
  wire ce_lvl_next  = settled_level(ce_sync_reg, ce_lvl_reg);
  wire clk_rise     = clk_lvl_next && !clk_lvl_reg;
  wire le_rise      = le_lvl_next && !le_lvl_reg;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      clk_lvl_reg <= latch_loader_pkg::SCLK_IDLE;
      dat_lvl_reg <= latch_loader_pkg::SDATA_IDLE;
    end else begin
      clk_lvl_reg <= clk_lvl_next;
      dat_lvl_reg <= dat_lvl_next;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      le_lvl_reg <= latch_loader_pkg::STROBE_IDLE;
      ce_lvl_reg <= latch_loader_pkg::CE_RESET_LVL;
    end else begin
      le_lvl_reg <= le_lvl_next;
      ce_lvl_reg <= ce_lvl_next;
    end
  end

  // ****************************************
  // Shift register and latches
  // ****************************************
  logic [WORD_W-1:0]  shift_reg;
  logic [LATCHES-1:0] written_reg;

  // Address bits are the last ones shifted in, so they sit at the bottom
  wire [ADDR_W-1:0]  addr_sel     = shift_reg[ADDR_W-1:0]; // [R10]
  wire               addr_ok      = addr_sel <= ADDR_TOP;
  wire [LATCHES-1:0] latch_hot    = latch_onehot(addr_sel);
  wire [LATCHES-1:0] commit_hot   = (le_rise && addr_ok) ? latch_hot : '0; // [R2]
  wire [WORD_W-1:0]  shift_next   = clk_rise ? {shift_reg[WORD_W-2:0], dat_lvl_reg} : shift_reg; // [R1] [R10]
  wire [LATCHES-1:0] written_next = written_reg | commit_hot;

  // A strobe rise in the cycle of a clock rise would commit a word one bit
  // short; the host keeps a gap of whole link half periods between them
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      shift_reg <= WORD_RESET;
    end else begin
      shift_reg <= shift_next;
    end
  end

  // Latches keep their contents through power-down; only a write or a reset changes them
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int k = 0; k < LATCHES; k++) begin
        latch_out[k] <= WORD_RESET;
      end
    end else begin
      for (int k = 0; k < LATCHES; k++) begin
        if (commit_hot[k]) begin
          latch_out[k] <= shift_reg; // [R2]
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      written_reg <= '0;
    end else begin
      written_reg <= written_next;
    end
  end

  // ****************************************
  // Status and power-down
  // ****************************************
  // Output goes live only once every latch has been loaded since reset
  wire all_written = &written_reg; // [R6]
  assign latch_written_out  = written_reg;
  assign outputs_active_out = all_written && ce_lvl_reg; // [R6]
  assign powered_down_out   = !ce_lvl_reg; // [R8]
  // Lock state passes straight out; the host resynchronises it
  // Status pin is held low in every mode other than lock detect
  assign link.selectable_status_pin = status_is_lock_in ? lock_in : 1'b0; // [R9]
endmodule

/* latch_loader_host.sv */
module latch_loader_host (
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  // User side
  input  wire logic        write_valid_in,
  input  wire logic [31:0] write_word_in,
  output logic             write_ready_out,
  input  wire logic        chip_enable_in,
  output logic             lock_out,
  // Serial link
  latch_loader_if.host     link
);
  timeunit 1ns;
  timeprecision 1ps;
  typedef enum logic [1:0] {
    IDLE  = 2'b00,
    LOW   = 2'b01,
    HIGH  = 2'b10,
    STRB  = 2'b11
  } host_state_e;

  host_state_e state_reg;
  logic [31:0] word_reg;
  logic [5:0]  bit_cnt_reg;
  logic [1:0]  div_reg;
  logic        sclk_reg;
  logic        sdat_reg;
  logic        le_reg;
  logic [2:0]  lock_sync_reg;
  logic        lock_reg;

  wire tick = div_reg == 2'(latch_loader_pkg::LINK_DIV / 2 - 1);
  assign write_ready_out = state_reg == IDLE;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg   <= IDLE;
      word_reg    <= 32'h0;
      bit_cnt_reg <= 6'h0;
      div_reg     <= 2'h0;
      sclk_reg    <= 1'b0;
      sdat_reg    <= 1'b0;
      le_reg      <= 1'b1;
    end else begin
      div_reg <= tick ? 2'h0 : div_reg + 2'h1;
      case (state_reg)
        IDLE: if (write_valid_in) begin
          word_reg    <= write_word_in;
          le_reg      <= 1'b0; // [R3]
          bit_cnt_reg <= 6'h0;
          div_reg     <= 2'h0;
          state_reg   <= LOW;
        end
        LOW: if (tick) begin
          sdat_reg  <= word_reg[31]; // [R7] [R10]
          word_reg  <= {word_reg[30:0], 1'b0};
          state_reg <= HIGH;
        end
        HIGH: if (tick) begin
          sclk_reg <= ~sclk_reg;
          if (sclk_reg) begin
            bit_cnt_reg <= bit_cnt_reg + 6'h1;
            state_reg   <= (bit_cnt_reg == 6'(latch_loader_pkg::WORD_BITS - 1)) ? STRB : LOW; // [R4]
          end
        end
        STRB: if (tick) begin
          le_reg    <= 1'b1; // [R5]
          state_reg <= IDLE;
        end
        default: state_reg <= IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      lock_sync_reg <= 3'h0;
      lock_reg      <= 1'b0;
    end else begin
      lock_sync_reg <= {lock_sync_reg[1:0], link.selectable_status_pin};
      if (lock_sync_reg[1] == lock_sync_reg[2]) lock_reg <= lock_sync_reg[2]; // [R9]
    end
  end

  assign link.serial_clk  = sclk_reg;
  assign link.serial_data = sdat_reg;
  assign link.load_strobe = le_reg;
  assign link.chip_enable = chip_enable_in; // [R8]
  assign lock_out         = lock_reg;
endmodule

/* latch_loader_chk.sv */
module latch_loader_chk (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Serial link
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic load_strobe,
  input wire logic chip_enable,
  input wire logic selectable_status_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  logic [5:0] bits_reg;
  logic       clk_d_reg;
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) clk_d_reg <= 1'b0;
    else clk_d_reg <= serial_clk;
  end
  // Counts clock rises within one frame
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) bits_reg <= 6'h00;
    else if (load_strobe) bits_reg <= 6'h00;
    else if (serial_clk && !clk_d_reg) bits_reg <= bits_reg + 6'h01;
  end
  chk_clk_in_frame: assert property ($rose(serial_clk) |-> !load_strobe) else $error("clock outside frame");
  chk_fall_gap: assert property ($fell(load_strobe) |-> !serial_clk [*2]) else $error("clock too soon");
  chk_data_settled: assert property ($rose(serial_clk) |-> $stable(serial_data)) else $error("data moved");
  chk_high_time: assert property ($rose(serial_clk) |=> serial_clk ##1 !serial_clk) else $error("high time");
  chk_low_time: assert property ($fell(serial_clk) |=> !serial_clk) else $error("low time");
  chk_idle_clk_low: assert property (load_strobe |-> !serial_clk) else $error("clock while idle");
  chk_word_bits: assert property ($rose(load_strobe) |-> bits_reg == 6'(latch_loader_pkg::WORD_BITS)) else $error("bit count");
  chk_frame_bound: assert property ($fell(load_strobe) |-> ##[100:300] $rose(load_strobe)) else $error("frame");
  cover property ($rose(load_strobe));
  cover property ($rose(selectable_status_pin));
  cover property ($fell(chip_enable));
endmodule

/* testbench.sv */
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst = 1'b1, valid = 1'b0, ce = 1'b1, lock = 1'b0, sel = 1'b0;
  logic [31:0] word = 32'h0, latch [0:5], exp_w [0:5];
  logic [5:0]  written;
  logic        ready, lock_seen, pdn, active;
  int          n_errors = 0, comparisons = 0, cycles = 0;
  latch_loader_if lnk();
  latch_loader_host u_latch_loader_host (.sys_clk_in(clk), .rst_in(rst), .write_valid_in(valid),
    .write_word_in(word), .write_ready_out(ready), .chip_enable_in(ce), .lock_out(lock_seen), .link(lnk));
  latch_loader_device u_latch_loader_device (.sys_clk_in(clk), .rst_in(rst), .link(lnk), .lock_in(lock),
    .status_is_lock_in(sel), .latch_out(latch), .latch_written_out(written), .powered_down_out(pdn),
    .outputs_active_out(active));
  latch_loader_chk u_chk (.sys_clk_in(clk), .rst_in(rst), .serial_clk(lnk.serial_clk),
    .serial_data(lnk.serial_data), .load_strobe(lnk.load_strobe), .chip_enable(lnk.chip_enable),
    .selectable_status_pin(lnk.selectable_status_pin));
  always #50 clk = ~clk;
  // ****
  // Bus tasks
  // ****
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [31:0] w);
    int t;
    t = 0;
    valid = 1'b1;
    word = w;
    wait_cyc(1);
    valid = 1'b0;
    while (ready !== 1'b1 && t < 400) begin wait_cyc(1); t++; end
    `CHK("ready", 1'b1, ready)
    // Device sees the strobe through its synchroniser
    wait_cyc(8);
  endtask
  task automatic close_out();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin n_errors++; close_out(); end
  end
  // ****
  // Tests
  // ****
  initial begin
    wait_cyc(2);
    rst = 1'b0;
    for (int i = 5; i >= 0; i--) begin
      `CHK("active early", 1'b0, active)
      exp_w[i] = {29'h0a5c_3e1 ^ 29'(i * 7), 3'(i)};
      wr(exp_w[i]);
      `CHK("latch", exp_w[i], latch[i])
      `CHK("written", 1'b1, written[i])
    end
    `CHK("active", 1'b1, active)
    wr(32'hffff_fffe);
    wr(32'hffff_ffff);
    for (int i = 0; i < 6; i++) `CHK("kept", exp_w[i], latch[i])
    ce = 1'b0;
    wait_cyc(6);
    `CHK("pdn", 1'b1, pdn)
    `CHK("active off", 1'b0, active)
    ce = 1'b1;
    sel = 1'b1;
    lock = 1'b1;
    wait_cyc(10);
    `CHK("pdn off", 1'b0, pdn)
    `CHK("lock", 1'b1, lock_seen)
    sel = 1'b0;
    wait_cyc(10);
    `CHK("no lock mode", 1'b0, lock_seen)
    // A second reset must not fake a strobe edge or a latch write
    rst = 1'b1;
    wait_cyc(2);
    rst = 1'b0;
    wait_cyc(8);
    `CHK("written after reset", 6'h00, written)
    `CHK("active after reset", 1'b0, active)
    close_out();
  end
endmodule
